// ---- common/lrd_pkg.sv ----
package lrd_pkg;

  // ---------------------------------------------------------------
  // Request type codes carried in bits one to three of a stream.
  // ---------------------------------------------------------------
  localparam logic [2:0] LRD_TYPE_IMM = 3'h0;
  localparam logic [2:0] LRD_TYPE_ISO = 3'h1;
  localparam logic [2:0] LRD_TYPE_PRI = 3'h2;
  localparam logic [2:0] LRD_TYPE_FAIR = 3'h3;
  localparam logic [2:0] LRD_TYPE_READ = 3'h4;
  localparam logic [2:0] LRD_TYPE_WRITE = 3'h5;
  localparam logic [2:0] LRD_TYPE_ACCEL = 3'h6;
  localparam logic [2:0] LRD_TYPE_RSV = 3'h7;

  // ---------------------------------------------------------------
  // Speed codes of a bus request.
  // ---------------------------------------------------------------
  localparam logic [2:0] LRD_SPEED_S100 = 3'h0;
  localparam logic [2:0] LRD_SPEED_S200 = 3'h2;
  localparam logic [2:0] LRD_SPEED_S400 = 3'h4;

  // ---------------------------------------------------------------
  // States of the interface control lines as the device drives them.
  // ---------------------------------------------------------------
  localparam logic [1:0] LRD_CTL_IDLE = 2'h0;
  localparam logic [1:0] LRD_CTL_STATUS = 2'h1;
  localparam logic [1:0] LRD_CTL_RECEIVE = 2'h2;
  localparam logic [1:0] LRD_CTL_GRANT = 2'h3;

  // ---------------------------------------------------------------
  // Bit positions within a request stream, bit 0 being the start bit.
  // ---------------------------------------------------------------
  localparam logic [4:0] LRD_BIT_TYPE_LAST = 5'h03;
  localparam logic [4:0] LRD_BIT_SPEED_FIRST = 5'h04;
  localparam logic [4:0] LRD_BIT_SPEED_LAST = 5'h06;
  localparam logic [4:0] LRD_BIT_ADDR_FIRST = 5'h04;
  localparam logic [4:0] LRD_BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] LRD_BIT_DATA_FIRST = 5'h08;
  localparam logic [4:0] LRD_BIT_DATA_LAST = 5'h0F;
  localparam logic [4:0] LRD_BIT_CTRL = 5'h04;
  localparam logic [4:0] LRD_STOP_BUS_LONG = 5'h07;
  localparam logic [4:0] LRD_STOP_READ = 5'h08;
  localparam logic [4:0] LRD_STOP_WRITE = 5'h10;
  localparam logic [4:0] LRD_STOP_ACCEL = 5'h05;

  // ---------------------------------------------------------------
  // Register map of the bus slave, byte addresses, and reset values.
  // ---------------------------------------------------------------
  localparam logic [7:0] LRD_OFS_CTRL = 8'h00;
  localparam logic [7:0] LRD_OFS_STATUS = 8'h04;
  localparam logic LRD_RST_DECODE_EN = 1'b1;
  localparam logic LRD_RST_ACCEL_EN = 1'b1;

  // ---------------------------------------------------------------
  // Carriers between the decoder, the core and the register port.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [2:0] rtype;
    logic [2:0] speed;
    logic [3:0] addr;
    logic [7:0] data;
    logic ctrl;
    logic rx_seen;
  } lrd_frame_t;

  typedef struct packed {
    logic strobe;
    logic [3:0] addr;
    logic [7:0] data;
  } lrd_regwr_t;

  typedef enum logic [2:0] {
    LRD_BK_NONE,
    LRD_BK_IMM,
    LRD_BK_ISO,
    LRD_BK_PRI,
    LRD_BK_FAIR
  } lrd_bus_kind_t;

  // Bus requests are the four types with a zero in the top type bit.
  function automatic logic lrd_is_bus_type(input logic [2:0] rtype);
    return !rtype[2];
  endfunction

  // Only three speed codes name a rate; the others are invalid.
  function automatic logic lrd_speed_valid(input logic [2:0] speed);
    return (speed == LRD_SPEED_S100) || (speed == LRD_SPEED_S200) || (speed == LRD_SPEED_S400);
  endfunction

endpackage

// ---- core/lrd_deser.sv ----
`timescale 1ns/1ps
`default_nettype none

// Frames and deserialises request streams, one bit per clock.
module lrd_deser (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic link_request_line,
  input wire logic [1:0] interface_control_lines,
  output lrd_pkg::lrd_frame_t frame
);

  typedef enum logic [1:0] {LRD_DS_IDLE, LRD_DS_SHIFT, LRD_DS_FLUSH} lrd_ds_state_t;

  typedef struct packed {
    lrd_ds_state_t st;
    logic [4:0] cnt;
    logic [2:0] rtype;
    logic [2:0] speed;
    logic [3:0] addr;
    logic [7:0] data;
    logic ctrl;
    logic rx_seen;
    lrd_pkg::lrd_frame_t frame;
  } lrd_ds_t;

  lrd_ds_t s_reg;
  lrd_ds_t s_next;
  logic bit_in;
  logic rx_now;
  logic [2:0] type_now;
  logic [4:0] stop_idx;

  assign bit_in = link_request_line;
  assign rx_now = (interface_control_lines == lrd_pkg::LRD_CTL_RECEIVE);
  assign type_now = {s_reg.rtype[1:0], bit_in};

  // Index of the stop bit for the non-bus types and for a long bus request.
  always_comb begin
    case (s_reg.rtype)
      lrd_pkg::LRD_TYPE_READ: stop_idx = lrd_pkg::LRD_STOP_READ;
      lrd_pkg::LRD_TYPE_WRITE: stop_idx = lrd_pkg::LRD_STOP_WRITE;
      lrd_pkg::LRD_TYPE_ACCEL: stop_idx = lrd_pkg::LRD_STOP_ACCEL;
      default: stop_idx = lrd_pkg::LRD_STOP_BUS_LONG;
    endcase
  end

  // Shifts each bit into its field by position and emits a frame at the stop bit.
  always_comb begin
    s_next = s_reg;
    s_next.frame.valid = 1'b0;
    case (s_reg.st)
      LRD_DS_IDLE: begin
        if (bit_in) begin
          s_next.st = LRD_DS_SHIFT;
          s_next.cnt = 5'h01;
          s_next.rx_seen = rx_now;
          s_next.rtype = 3'h0;
          s_next.speed = 3'h0;
          s_next.addr = 4'h0;
          s_next.data = 8'h00;
          s_next.ctrl = 1'b0;
        end
      end
      LRD_DS_SHIFT: begin
        s_next.cnt = s_reg.cnt + 5'h01;
        s_next.rx_seen = s_reg.rx_seen | rx_now;
        // The first bit after the start is the type's most significant bit.
        if (s_reg.cnt <= lrd_pkg::LRD_BIT_TYPE_LAST) begin
          s_next.rtype = type_now;
        end
        if (s_reg.cnt >= lrd_pkg::LRD_BIT_SPEED_FIRST && s_reg.cnt <= lrd_pkg::LRD_BIT_SPEED_LAST) begin
          s_next.speed = {s_reg.speed[1:0], bit_in};
        end
        if (s_reg.cnt >= lrd_pkg::LRD_BIT_ADDR_FIRST && s_reg.cnt <= lrd_pkg::LRD_BIT_ADDR_LAST) begin
          s_next.addr = {s_reg.addr[2:0], bit_in};
        end
        if (s_reg.cnt >= lrd_pkg::LRD_BIT_DATA_FIRST && s_reg.cnt <= lrd_pkg::LRD_BIT_DATA_LAST) begin
          s_next.data = {s_reg.data[6:0], bit_in};
        end
        if (s_reg.cnt == lrd_pkg::LRD_BIT_CTRL) begin
          s_next.ctrl = bit_in;
        end
        // A reserved type is dropped with no effect at all.
        if (s_reg.cnt == lrd_pkg::LRD_BIT_TYPE_LAST && type_now == lrd_pkg::LRD_TYPE_RSV) begin
          s_next.st = LRD_DS_FLUSH;
        end else if (lrd_pkg::lrd_is_bus_type(s_reg.rtype) && s_reg.cnt == lrd_pkg::LRD_BIT_SPEED_LAST &&
                     !bit_in) begin
          s_next.st = LRD_DS_IDLE;
          s_next.frame = '{1'b1, s_reg.rtype, s_next.speed, s_next.addr, s_next.data, s_next.ctrl, s_next.rx_seen};
        end else if (s_reg.cnt > lrd_pkg::LRD_BIT_TYPE_LAST && s_reg.cnt == stop_idx) begin
          if (!bit_in) begin
            s_next.st = LRD_DS_IDLE;
            s_next.frame = '{1'b1, s_reg.rtype, s_next.speed, s_next.addr, s_next.data, s_next.ctrl,
                             s_next.rx_seen};
          end else begin
            s_next.st = LRD_DS_FLUSH;
          end
        end
      end
      LRD_DS_FLUSH: begin
        // A broken stream is skipped until the line is low for a cycle.
        if (!bit_in) begin
          s_next.st = LRD_DS_IDLE;
        end
      end
      default: s_next.st = LRD_DS_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign frame = s_reg.frame;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_start_opens_frame: assert property (s_reg.st == LRD_DS_IDLE && link_request_line |=> s_reg.st == LRD_DS_SHIFT)
    else $error("start bit did not open a stream");
  a_reserved_type_dropped: assert property (s_reg.st == LRD_DS_SHIFT && s_reg.cnt == lrd_pkg::LRD_BIT_TYPE_LAST &&
    type_now == lrd_pkg::LRD_TYPE_RSV |=> s_reg.st == LRD_DS_FLUSH ##1 !frame.valid)
    else $error("reserved request was not discarded");
  a_write_len_exact: assert property (frame.valid && frame.rtype == lrd_pkg::LRD_TYPE_WRITE |->
    $past(s_reg.cnt) == lrd_pkg::LRD_STOP_WRITE)
    else $error("write request ended at wrong length");

endmodule // lrd_deser

`default_nettype wire

// ---- core/lrd_top.sv ----
// Function
// - Every stream starts with a one bit and ends with a zero stop bit.
// - Bit 0 goes first as most significant; bits one to three give type.
// - Immediate request: on idle, take the bus at once, no arbitration.
// - Isochronous request: on idle, arbitrate without waiting for subaction gap.
// - Priority request: arbitrate after subaction gap, ignoring fairness.
// - Fair request: arbitrate after subaction gap, obeying fairness.
// - Types read, write and acceleration control act on registers; 111 reserved.
// - Bus request speed in bits four to six; 000, 010, 100 valid.
// - Bus request is seven or eight bits; accept both lengths.
// - Invalid speed still arbitrates, but transmission sends a null packet.
// - Read request: nine bits, address in bits four to seven.
// - Write request: seventeen bits, address then eight data bits.
// - Acceleration control: six bits, bit four enables or disables.
// - Driving the receive state drops pending fair or priority request.
// - Fair or priority request shifted in during receive is ignored.
// - Pending isochronous request clears only when the bus is won or on bus reset.
// - Request line sampled one bit per rising interface clock edge.
// - One bus request pending; ignore others; bus reset clears all; a request arriving in the bus reset cycle is kept.
// - Write data enters the register as soon as the stream completes.
// - Pending read ignores further reads and survives bus reset.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Decodes link service requests and keeps the pending request state.
module lrd_top #(
  parameter int ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic link_request_line,
  input wire logic [1:0] interface_control_lines,
  input wire logic subaction_gap,
  input wire logic bus_won,
  input wire logic bus_lost,
  input wire logic bus_reset,
  input wire logic read_status_sent,
  output logic take_bus_now,
  output logic arbitrate_now,
  output logic fairness_enforced,
  output logic null_packet_tx,
  output lrd_pkg::lrd_regwr_t reg_write,
  output logic read_pending,
  output logic [3:0] read_addr,
  output logic accel_enable,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);

  typedef struct packed {
    lrd_pkg::lrd_bus_kind_t kind;
    logic speed_bad;
    logic take_bus;
    logic arbitrate;
    logic fair;
    lrd_pkg::lrd_regwr_t wr;
    logic rd_pend;
    logic [3:0] rd_addr;
    logic accel;
  } lrd_core_t;

  lrd_core_t s_reg;
  lrd_core_t s_next;
  lrd_pkg::lrd_frame_t frame;
  logic decode_enable;
  logic ctl_idle;
  logic ctl_receive;
  logic pf_pending;
  logic frame_take;
  logic [31:0] status_word;
  lrd_pkg::lrd_bus_kind_t frame_kind;
  logic bus_accept;

  // ---------------------------------------------------------------
  // Stream framing and register port
  // ---------------------------------------------------------------
  lrd_deser u_deser (
    .clk_sys(clk_sys),
    .rst(rst),
    .link_request_line(link_request_line),
    .interface_control_lines(interface_control_lines),
    .frame(frame)
  );

  lrd_wb #(
    .ADR_W(ADR_W)
  ) u_wb (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_adr(wb_adr),
    .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack),
    .status_word(status_word),
    .decode_enable(decode_enable)
  );

  // Status word shows the pending requests and acceleration state.
  assign status_word = {22'h000000, s_reg.accel, s_reg.rd_addr, s_reg.rd_pend, s_reg.speed_bad, s_reg.kind};

  // ---------------------------------------------------------------
  // Request decode and pending state
  // ---------------------------------------------------------------
  assign ctl_idle = (interface_control_lines == lrd_pkg::LRD_CTL_IDLE);
  assign ctl_receive = (interface_control_lines == lrd_pkg::LRD_CTL_RECEIVE);
  assign pf_pending = (s_reg.kind == lrd_pkg::LRD_BK_PRI) || (s_reg.kind == lrd_pkg::LRD_BK_FAIR);
  assign frame_take = frame.valid && decode_enable;

  // Maps a bus request type onto the pending kind.
  always_comb begin
    case (frame.rtype)
      lrd_pkg::LRD_TYPE_IMM: frame_kind = lrd_pkg::LRD_BK_IMM;
      lrd_pkg::LRD_TYPE_ISO: frame_kind = lrd_pkg::LRD_BK_ISO;
      lrd_pkg::LRD_TYPE_PRI: frame_kind = lrd_pkg::LRD_BK_PRI;
      lrd_pkg::LRD_TYPE_FAIR: frame_kind = lrd_pkg::LRD_BK_FAIR;
      default: frame_kind = lrd_pkg::LRD_BK_NONE;
    endcase
  end

  // Clears come first so that a request arriving in the same cycle wins.
  always_comb begin
    s_next = s_reg;
    s_next.wr.strobe = 1'b0;
    bus_accept = 1'b0;
    if (bus_reset) begin
      s_next.kind = lrd_pkg::LRD_BK_NONE;
    end else if (bus_won) begin
      s_next.kind = lrd_pkg::LRD_BK_NONE;
    end else if (bus_lost && s_reg.kind != lrd_pkg::LRD_BK_ISO) begin
      s_next.kind = lrd_pkg::LRD_BK_NONE;
    end else if (ctl_receive && pf_pending) begin
      s_next.kind = lrd_pkg::LRD_BK_NONE;
    end
    if (read_status_sent) begin
      s_next.rd_pend = 1'b0;
    end
    if (frame_take) begin
      case (frame.rtype)
        lrd_pkg::LRD_TYPE_IMM, lrd_pkg::LRD_TYPE_ISO, lrd_pkg::LRD_TYPE_PRI, lrd_pkg::LRD_TYPE_FAIR: begin
          // Fair and priority requests that overlapped a receive are ignored.
          if (s_next.kind == lrd_pkg::LRD_BK_NONE &&
              !((frame_kind == lrd_pkg::LRD_BK_PRI || frame_kind == lrd_pkg::LRD_BK_FAIR) &&
                (frame.rx_seen || ctl_receive))) begin
            s_next.kind = frame_kind;
            s_next.speed_bad = !lrd_pkg::lrd_speed_valid(frame.speed);
            bus_accept = 1'b1;
          end
        end
        lrd_pkg::LRD_TYPE_READ: begin
          if (!s_next.rd_pend) begin
            s_next.rd_pend = 1'b1;
            s_next.rd_addr = frame.addr;
          end
        end
        lrd_pkg::LRD_TYPE_WRITE: begin
          s_next.wr = '{1'b1, frame.addr, frame.data};
        end
        lrd_pkg::LRD_TYPE_ACCEL: begin
          s_next.accel = frame.ctrl;
        end
        default: s_next.wr.strobe = 1'b0;
      endcase
    end
    // Arbitration commands follow from what is pending this cycle.
    s_next.take_bus = (s_reg.kind == lrd_pkg::LRD_BK_IMM) && ctl_idle;
    s_next.arbitrate = ((s_reg.kind == lrd_pkg::LRD_BK_ISO) && ctl_idle) ||
                       (pf_pending && subaction_gap);
    s_next.fair = (s_reg.kind == lrd_pkg::LRD_BK_FAIR);
    // The null-packet flag lives only as long as the bus request that raised it.
    s_next.speed_bad = s_next.speed_bad && (s_next.kind != lrd_pkg::LRD_BK_NONE);
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '{lrd_pkg::LRD_BK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, '0, 1'b0, 4'h0, lrd_pkg::LRD_RST_ACCEL_EN};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register.
  assign take_bus_now = s_reg.take_bus;
  assign arbitrate_now = s_reg.arbitrate;
  assign fairness_enforced = s_reg.fair;
  assign null_packet_tx = s_reg.speed_bad;
  assign reg_write = s_reg.wr;
  assign read_pending = s_reg.rd_pend;
  assign read_addr = s_reg.rd_addr;
  assign accel_enable = s_reg.accel;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_clears_bus: assert property (bus_reset && !bus_accept |=> s_reg.kind == lrd_pkg::LRD_BK_NONE)
    else $error("bus reset left a bus request pending");
  a_one_bus_pending: assert property (s_reg.kind != lrd_pkg::LRD_BK_NONE && !bus_reset && !bus_won && !bus_lost &&
    !ctl_receive |=> $stable(s_reg.kind))
    else $error("pending bus request changed without cause");
  a_iso_held_till_won: assert property (s_reg.kind == lrd_pkg::LRD_BK_ISO && !bus_won && !bus_reset |=>
    s_reg.kind == lrd_pkg::LRD_BK_ISO)
    else $error("isochronous request dropped before winning");
  a_receive_drops_pf: assert property (ctl_receive && pf_pending |=>
    s_reg.kind != lrd_pkg::LRD_BK_PRI && s_reg.kind != lrd_pkg::LRD_BK_FAIR)
    else $error("receive state kept a fair or priority request");
  a_pf_rx_ignored: assert property (frame_take && frame.rx_seen && s_reg.kind == lrd_pkg::LRD_BK_NONE &&
    (frame.rtype == lrd_pkg::LRD_TYPE_PRI || frame.rtype == lrd_pkg::LRD_TYPE_FAIR) |=>
    s_reg.kind == lrd_pkg::LRD_BK_NONE)
    else $error("request overlapping receive was accepted");
  a_imm_takes_bus: assert property (s_reg.kind == lrd_pkg::LRD_BK_IMM && ctl_idle |=>
    take_bus_now && !arbitrate_now)
    else $error("immediate request did not take the bus");
  a_iso_arbitrates: assert property (s_reg.kind == lrd_pkg::LRD_BK_ISO && ctl_idle |=>
    arbitrate_now && !fairness_enforced)
    else $error("isochronous request did not arbitrate on idle");
  a_pri_no_fair: assert property (s_reg.kind == lrd_pkg::LRD_BK_PRI && subaction_gap |=>
    arbitrate_now && !fairness_enforced)
    else $error("priority request arbitration wrong");
  a_fair_obeys: assert property (s_reg.kind == lrd_pkg::LRD_BK_FAIR && subaction_gap |=>
    arbitrate_now && fairness_enforced)
    else $error("fair request arbitration wrong");
  a_write_lands: assert property (frame_take && frame.rtype == lrd_pkg::LRD_TYPE_WRITE |=>
    reg_write.strobe && reg_write.addr == $past(frame.addr) && reg_write.data == $past(frame.data) ##1
    !reg_write.strobe)
    else $error("register write not issued once");
  a_read_held: assert property (read_pending && !read_status_sent |=> read_pending && $stable(read_addr))
    else $error("pending read lost or changed");
  a_accel_follows: assert property (frame_take && frame.rtype == lrd_pkg::LRD_TYPE_ACCEL |=>
    accel_enable == $past(frame.ctrl))
    else $error("acceleration control not applied");
  a_bad_speed_null: assert property (bus_accept && !lrd_pkg::lrd_speed_valid(frame.speed) |=>
    null_packet_tx)
    else $error("invalid speed did not select null packet");
  a_good_speed_tx: assert property (bus_accept && lrd_pkg::lrd_speed_valid(frame.speed) |=>
    !null_packet_tx)
    else $error("valid speed selected null packet");
  a_lost_clears_req: assert property (bus_lost && s_reg.kind != lrd_pkg::LRD_BK_ISO && !bus_accept |=>
    s_reg.kind == lrd_pkg::LRD_BK_NONE)
    else $error("lost arbitration left a request pending");
  a_read_taken: assert property (frame_take && frame.rtype == lrd_pkg::LRD_TYPE_READ && !read_pending |=>
    read_pending && read_addr == $past(frame.addr))
    else $error("read request not recorded");
  a_status_clears_read: assert property (read_status_sent &&
    !(frame_take && frame.rtype == lrd_pkg::LRD_TYPE_READ) |=> !read_pending)
    else $error("status transfer left read pending");

  c_imm_accepted: cover property (frame_take && frame.rtype == lrd_pkg::LRD_TYPE_IMM ##1 take_bus_now);
  c_iso_won: cover property (s_reg.kind == lrd_pkg::LRD_BK_ISO ##1 bus_won);
  c_write_done: cover property (reg_write.strobe);
  c_read_pending: cover property (read_pending ##1 read_status_sent);
  c_pf_lost: cover property (pf_pending ##1 bus_lost);

endmodule // lrd_top

`default_nettype wire

// ---- core/lrd_wb.sv ----
`timescale 1ns/1ps
`default_nettype none

// Classic Wishbone slave holding the control word and showing core status.
module lrd_wb #(
  parameter int ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic [31:0] status_word,
  output logic decode_enable
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat_r;
    logic en;
  } lrd_wb_t;

  lrd_wb_t s_reg;
  lrd_wb_t s_next;
  logic [7:0] adr8;

  if (ADR_W < 3 || ADR_W > 8) begin : g_bad_adr
    $error("lrd_wb: ADR_W must lie between 3 and 8");
  end

  assign adr8 = 8'(wb_adr);

  // Answers each access one cycle after it starts; unmapped reads give zero.
  always_comb begin
    s_next = s_reg;
    s_next.ack = wb_cyc && wb_stb && !s_reg.ack;
    s_next.dat_r = 32'h00000000;
    if (s_next.ack) begin
      if (wb_we && adr8 == lrd_pkg::LRD_OFS_CTRL && wb_sel[0]) begin
        s_next.en = wb_dat_w[0];
      end
      if (!wb_we) begin
        case (adr8)
          lrd_pkg::LRD_OFS_CTRL: s_next.dat_r = {31'h00000000, s_reg.en};
          lrd_pkg::LRD_OFS_STATUS: s_next.dat_r = status_word;
          default: s_next.dat_r = 32'h00000000;
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '{1'b0, 32'h00000000, lrd_pkg::LRD_RST_DECODE_EN};
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack = s_reg.ack;
  assign wb_dat_r = s_reg.dat_r;
  assign decode_enable = s_reg.en;

endmodule // lrd_wb

`default_nettype wire

// ---- testbench/link_request_stream_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// Sends request streams through the link model and checks the decoded results.
module link_request_stream_decoder_tb;
  typedef struct packed {logic [16:0] b; logic [4:0] n; logic [3:0] e;} lrd_row_t;
  logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0, won = 1'b0, brst = 1'b0, cyc = 1'b0, we = 1'b0;
  logic lost = 1'b0, rss = 1'b0;
  logic [1:0] ctl = 2'h0;
  logic [16:0] bits = 17'h00000;
  logic [4:0] len = 5'h00;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rd, dat_r;
  logic line, take, arb, fair, nul, rdp, acc, ack;
  logic [3:0] radr;
  lrd_pkg::lrd_regwr_t rw;
  int failures = 0, num_checks = 0, k;
  lrd_row_t rows [5] = '{
    '{{1'b1, 3'h0, 3'h0, 10'h000}, 5'h07, 4'h8},
    '{{1'b1, 3'h2, 3'h4, 10'h000}, 5'h08, 4'h4},
    '{{1'b1, 3'h1, 3'h2, 10'h000}, 5'h08, 4'h4},
    '{{1'b1, 3'h3, 3'h3, 10'h000}, 5'h08, 4'h7},
    '{{1'b1, 3'h7, 3'h0, 10'h000}, 5'h08, 4'h0}};
  always #5 clk_sys = ~clk_sys;
  lrd_link_model link (.clk_sys(clk_sys), .rst(rst), .go(go), .bits(bits), .len(len), .link_request_line(line));
  lrd_top dut (.clk_sys(clk_sys), .rst(rst), .link_request_line(line), .interface_control_lines(ctl),
    .subaction_gap(1'b1), .bus_won(won), .bus_lost(lost), .bus_reset(brst), .read_status_sent(rss),
    .take_bus_now(take), .arbitrate_now(arb), .fairness_enforced(fair), .null_packet_tx(nul),
    .reg_write(rw), .read_pending(rdp), .read_addr(radr), .accel_enable(acc), .wb_cyc(cyc), .wb_stb(cyc),
    .wb_we(we), .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(wdat), .wb_dat_r(dat_r), .wb_ack(ack));
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Launches one stream; the model puts bit 0 on the line after the next edge.
  task automatic send(input logic [16:0] b, input logic [4:0] n, input int wait_n);
    bits <= b;
    len <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (wait_n) @(posedge clk_sys);
  endtask
  // Raises one input for a cycle: 0 won, 1 bus reset, 2 receive state, 3 status sent, 4 lost.
  task automatic pulse(input logic [2:0] w);
    won <= (w == 3'h0);
    brst <= (w == 3'h1);
    ctl <= (w == 3'h2) ? 2'h2 : 2'h0;
    rss <= (w == 3'h3);
    lost <= (w == 3'h4);
    @(posedge clk_sys);
    {won, brst, rss, lost} <= 4'h0;
    ctl <= 2'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Classic Wishbone cycle held until ack is sampled high at a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 8);
    if (ack !== 1'b1) begin
      failures++;
      summarize();
    end
    rd = dat_r;
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(acc === 1'b1 && {take, arb, fair, nul, rdp, rw.strobe, ack} === 7'h00, "reset values");
    @(posedge clk_sys);
    foreach (rows[i]) begin
      send(rows[i].b, rows[i].n, 24);
      chk({take, arb, fair, nul} === rows[i].e, "bus request outcome");
      pulse(3'h0);
      chk({take, arb, nul} === 3'h0, "cleared by win");
    end
    send({1'b1, 3'h5, 4'hA, 8'hA5, 1'b0}, 5'h11, 0);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (rw.strobe !== 1'b1 && k < 30);
    chk(k == 19 && rw.addr === 4'hA && rw.data === 8'hA5, "write strobe");
    @(posedge clk_sys);
    send({1'b1, 3'h4, 4'h9, 1'b0, 8'h00}, 5'h09, 12);
    send({1'b1, 3'h4, 4'h3, 1'b0, 8'h00}, 5'h09, 12);
    pulse(3'h1);
    chk(rdp === 1'b1 && radr === 4'h9, "read kept");
    wb(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h00000330, "status word");
    wb(1'b0, 8'h08, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    pulse(3'h3);
    chk(rdp === 1'b0, "status sent clears read");
    send({1'b1, 3'h6, 1'b0, 1'b0, 11'h000}, 5'h06, 10);
    chk(acc === 1'b0, "accel off");
    send({1'b1, 3'h0, 3'h0, 10'h000}, 5'h07, 12);
    send({1'b1, 3'h3, 3'h0, 10'h000}, 5'h08, 12);
    chk(take === 1'b1 && fair === 1'b0, "second bus request");
    pulse(3'h1);
    chk(take === 1'b0, "bus reset clear");
    send({1'b1, 3'h3, 3'h0, 10'h000}, 5'h08, 12);
    pulse(3'h2);
    chk(arb === 1'b0, "receive drops fair");
    send({1'b1, 3'h2, 3'h0, 10'h000}, 5'h08, 2);
    pulse(3'h2);
    repeat (8) @(posedge clk_sys);
    chk(arb === 1'b0, "priority during receive");
    send({1'b1, 3'h2, 3'h0, 10'h000}, 5'h08, 12);
    chk(arb === 1'b1 && fair === 1'b0, "priority resent after idle");
    pulse(3'h4);
    chk(arb === 1'b0, "lost clears priority");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h0, "control readback");
    send({1'b1, 3'h0, 3'h0, 10'h000}, 5'h07, 12);
    chk(take === 1'b0, "decode disabled");
    summarize();
  end
endmodule // link_request_stream_decoder_tb
`default_nettype wire

// ---- testbench/lrd_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Link side: shifts a left-aligned stream onto the request line, one bit per rising edge.
module lrd_link_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [16:0] bits,
  input wire logic [4:0] len,
  output logic link_request_line
);
  logic [16:0] sh_reg;
  logic [4:0] cnt_reg;
  // The line is held low whenever no stream is being sent.
  assign link_request_line = (cnt_reg != 5'h00) & sh_reg[16];
  // The first bit loaded goes out first, one bit per cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh_reg <= 17'h00000;
      cnt_reg <= 5'h00;
    end else if (go) begin
      sh_reg <= bits;
      cnt_reg <= len;
    end else if (cnt_reg != 5'h00) begin
      sh_reg <= sh_reg << 1;
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule // lrd_link_model
`default_nettype wire
